/* File: core/sfm_top.sv */
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "sfm_map.svh"
// Overview of operation
// [RQ1] out-of-range sensor forces reset or exception
// [RQ2] ram parity checked on every read
// [RQ3] scrubber checks whole ram, random order, idle
// [RQ4] any ram parity error forces security reset
// [RQ5] reset restores defaults, cause kept readable
// [RQ6] exception reason readable in status register
// [RQ7] no register write disables sensor monitoring
// [RQ8] three stack pointers with own limits
// [RQ9] stack pointer beyond limits raises exception
// [RQ10] high-voltage check per write, status only
// [RQ11] eeprom single-bit error per byte corrected
// [RQ12] rom parity checked too, errors force reset
// [RQ13] inverse correction option makes errors exceptions
// [RQ14] software switches eeprom double read
// [RQ15] program watchdog enabled and configured by software
// [RQ16] reset fault outranks same-cycle exception fault
module sfm_top #(
  parameter int            NS            = 4,
  parameter logic [NS-1:0] SENS_RST_MASK = '1,
  parameter int            RAM_AW        = 12,
  parameter int            SPW           = 16
)(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic [7:0]             paddr,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic [NS-1:0]          sens_alarm,
  input  wire logic                   hv_ok,
  input  wire logic                   ee_wr_busy,
  input  wire logic                   ram_rd_valid,
  input  wire logic [31:0]            ram_rd_data,
  input  wire logic [3:0]             ram_rd_par,
  input  wire logic                   ram_idle,
  output logic                        scrub_req,
  output logic [RAM_AW-1:0]           scrub_addr,
  input  wire logic                   scrub_rvalid,
  input  wire logic [31:0]            scrub_rdata,
  input  wire logic [3:0]             scrub_rpar,
  input  wire logic                   rom_rd_valid,
  input  wire logic [31:0]            rom_rd_data,
  input  wire logic [3:0]             rom_rd_par,
  input  wire logic                   ee_rd_valid,
  input  wire logic [7:0]             ee_rd_data,
  input  wire logic [3:0]             ee_rd_chk,
  output logic                        ee_corr_valid,
  output logic [7:0]                  ee_corr_data,
  output logic                        dbl_read_en,
  input  wire sfm_pkg::sfm_mode_type  cpu_mode,
  input  wire logic                   sp_wr_en,
  input  wire logic [SPW-1:0]         sp_wr_val,
  output logic [SPW-1:0]              active_sp,
  output logic                        sec_reset,
  output logic                        irq
);
  import sfm_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic                    pready;
    logic                    pslverr;
    logic [31:0]             prdata;
    logic [`SFM_CTRL_W-1:0]  ctrl;
    logic [`SFM_WDG_W-1:0]   wdg_load;
    logic [`SFM_WDG_W-1:0]   wdg_cnt;
    logic [`SFM_EXC_W-1:0]   exc_stat;
    logic [`SFM_EXC_W-1:0]   exc_en;
    logic [`SFM_CAUSE_W-1:0] cause;
    logic                    hv_fail;
    logic                    hv_busy;
    logic [2:0][SPW-1:0]     sp;
    logic [2:0][SPW-1:0]     lim_lo;
    logic [2:0][SPW-1:0]     lim_hi;
    logic [NS:0]             sy1;
    logic [NS:0]             sy2;
    logic [NS:0]             sy3;
    logic [`SFM_RCNT_W-1:0]  rst_cnt;
    logic                    sec_reset;
    logic                    irq;
    logic [SPW-1:0]          active_sp;
  } sfm_top_state_type;

  localparam int RST_CYC = (`SFM_RST_NS + `SFM_CLK_NS - 1) / `SFM_CLK_NS;
  localparam sfm_top_state_type RST_STATE = '{
    wdg_load: `SFM_WDG_RST,
    wdg_cnt:  `SFM_WDG_RST,
    lim_hi:   '1,
    // hv bit starts at its good level, so no false loss follows reset
    sy1:      {1'b1, NS'(0)},
    sy2:      {1'b1, NS'(0)},
    sy3:      {1'b1, NS'(0)},
    cause:    `SFM_CAUSE_W'(1 << `SFM_CA_POR),
    default:  '0
  };

  sfm_top_state_type s_q, s_d;

  logic [NS-1:0]           sens_f;
  logic                    hv_lost;
  logic [1:0]              mi;
  logic                    sp_oob;
  logic [`SFM_CAUSE_W-1:0] rst_ev;
  logic [`SFM_EXC_W-1:0]   exc_ev;
  logic [`SFM_EXC_W-1:0]   exc_set;
  logic                    acc_wr;
  logic                    sp_hit;
  logic [1:0]              si;

  sfm_sub_if #(.AW(RAM_AW)) sub_if ();

  // unknown mode codes fall to the most privileged pointer
  function automatic logic [1:0] mode_idx(input sfm_mode_type m);
    return (m == SFM_USER) ? 2'h0 : (m == SFM_SYS) ? 2'h1 : 2'h2;
  endfunction : mode_idx

  // limit registers: lo at even word, hi at odd word, per mode
  function automatic logic [1:0] sp_sel(input logic [7:0] a);
    logic [7:0] o;
    o = a - `SFM_OFF_SP_BASE;
    return o[`SFM_SP_STRIDE_SH +: 2];
  endfunction : sp_sel

  // ==========================================================
  // helpers
  sfm_scrub #(.AW(RAM_AW)) u_scrub (
    .clk   (pclk),
    .rst_n (presetn),
    .bus   (sub_if)
  );

  sfm_ecc u_ecc (
    .clk   (pclk),
    .rst_n (presetn),
    .bus   (sub_if)
  );

  // memory side hookup
  assign sub_if.ram_idle = ram_idle;
  assign sub_if.scrub_rvalid = scrub_rvalid;
  assign sub_if.scrub_rdata = scrub_rdata;
  assign sub_if.scrub_rpar = scrub_rpar;
  assign sub_if.ee_valid = ee_rd_valid;
  assign sub_if.ee_data = ee_rd_data;
  assign sub_if.ee_chk = ee_rd_chk;
  assign scrub_req = sub_if.scrub_req;
  assign scrub_addr = sub_if.scrub_addr;
  assign ee_corr_valid = sub_if.corr_valid;
  assign ee_corr_data = sub_if.corr_data;

  // ==========================================================
  // fault events; sensors have no enable bit anywhere
  assign sens_f = s_q.sy2[NS-1:0] & s_q.sy3[NS-1:0]; // RQ7
  assign hv_lost = !s_q.sy2[NS] && !s_q.sy3[NS];
  assign mi = mode_idx(cpu_mode);
  assign sp_oob = sp_wr_en && (sp_wr_val < s_q.lim_lo[mi] || sp_wr_val > s_q.lim_hi[mi]);
  assign acc_wr = psel && penable && s_q.pready && pwrite;
  assign sp_hit = paddr >= `SFM_OFF_SP_BASE && paddr <= `SFM_OFF_SP_LAST && paddr[1:0] == 2'h0;
  assign si = sp_sel(paddr);

  // reset-forcing and exception-raising events
  always_comb
  begin
    rst_ev = '0;
    rst_ev[`SFM_CA_SENS] = |(sens_f & SENS_RST_MASK); // RQ1
    rst_ev[`SFM_CA_RAM] = ram_rd_valid && sfm_par4(ram_rd_data) != ram_rd_par; // RQ2
    rst_ev[`SFM_CA_SCRUB] = sub_if.scrub_err; // RQ4
    rst_ev[`SFM_CA_ROM] = rom_rd_valid && sfm_par4(rom_rd_data) != rom_rd_par; // RQ12
    rst_ev[`SFM_CA_WDG] = s_q.ctrl[`SFM_CTRL_WDGEN] && s_q.wdg_cnt == '0; // RQ15
    exc_ev = '0;
    exc_ev[`SFM_EX_SENS] = |(sens_f & ~SENS_RST_MASK); // RQ1
    exc_ev[`SFM_EX_ECC] = sub_if.ecc_err && s_q.ctrl[`SFM_CTRL_INVECC]; // RQ13
    if (sp_oob)
      exc_ev[`SFM_EX_SPU + mi] = 1'b1; // RQ9
    exc_set = (|rst_ev) ? '0 : exc_ev; // RQ16
  end

  // ==========================================================
  // next state
  always_comb
  begin
    s_d = s_q;
    // analog inputs cross via three flops
    s_d.sy1 = {hv_ok, sens_alarm};
    s_d.sy2 = s_q.sy1;
    s_d.sy3 = s_q.sy2;
    // apb: answer in the second access cycle, data ready with it
    s_d.pready = psel && penable && !s_q.pready;
    if (psel && penable && !s_q.pready)
    begin
      s_d.pslverr = 1'b0;
      s_d.prdata = '0;
      if (sp_hit)
        s_d.prdata = 32'(paddr[`SFM_SP_HI_BIT] ? s_q.lim_hi[si] : s_q.lim_lo[si]);
      else
        case (paddr)
          `SFM_OFF_CTRL:     s_d.prdata = 32'(s_q.ctrl);
          `SFM_OFF_WDG_LOAD: s_d.prdata = 32'(s_q.wdg_load);
          `SFM_OFF_EXC_STAT: s_d.prdata = 32'(s_q.exc_stat); // RQ6
          `SFM_OFF_EXC_EN:   s_d.prdata = 32'(s_q.exc_en);
          `SFM_OFF_CAUSE:    s_d.prdata = 32'(s_q.cause); // RQ5
          `SFM_OFF_HV_STAT:  s_d.prdata = 32'({s_q.hv_busy, s_q.hv_fail}); // RQ10
          `SFM_OFF_WDG_KICK, `SFM_OFF_EXC_CLR: s_d.prdata = '0;
          default:           s_d.pslverr = 1'b1;
        endcase
    end
    // high-voltage result: cleared at start of write, kept after
    s_d.hv_busy = ee_wr_busy;
    if (ee_wr_busy && !s_q.hv_busy)
      s_d.hv_fail = 1'b0; // RQ10
    if (ee_wr_busy && hv_lost)
      s_d.hv_fail = 1'b1; // RQ10
    // watchdog down-counter; expiry forces a reset, which loads the default count
    if (s_q.ctrl[`SFM_CTRL_WDGEN])
      s_d.wdg_cnt = (s_q.wdg_cnt == '0) ? s_q.wdg_load : s_q.wdg_cnt - 1'b1; // RQ15
    // stack pointers, one per mode
    if (sp_wr_en)
      s_d.sp[mi] = sp_wr_val; // RQ8
    // register writes
    if (acc_wr)
    begin
      if (sp_hit && paddr[`SFM_SP_HI_BIT])
        s_d.lim_hi[si] = pwdata[SPW-1:0]; // RQ8
      else if (sp_hit)
        s_d.lim_lo[si] = pwdata[SPW-1:0]; // RQ8
      else
        case (paddr)
          `SFM_OFF_CTRL:     s_d.ctrl = pwdata[`SFM_CTRL_W-1:0]; // RQ14
          `SFM_OFF_WDG_LOAD: s_d.wdg_load = pwdata[`SFM_WDG_W-1:0]; // RQ15
          `SFM_OFF_WDG_KICK: s_d.wdg_cnt = s_q.wdg_load; // RQ15
          `SFM_OFF_EXC_CLR:  s_d.exc_stat = s_q.exc_stat & ~pwdata[`SFM_EXC_W-1:0];
          `SFM_OFF_EXC_EN:   s_d.exc_en = pwdata[`SFM_EXC_W-1:0];
          default:           s_d.ctrl = s_d.ctrl;
        endcase
    end
    // sticky reasons: a new event beats a clear in the same cycle
    s_d.exc_stat = s_d.exc_stat | exc_set; // RQ6
    // forced reset: defaults back, cause recorded, pulse restarted
    if (|rst_ev)
    begin
      s_d.ctrl = RST_STATE.ctrl; // RQ5
      s_d.wdg_load = RST_STATE.wdg_load;
      s_d.wdg_cnt = RST_STATE.wdg_cnt;
      s_d.exc_stat = RST_STATE.exc_stat;
      s_d.exc_en = RST_STATE.exc_en;
      s_d.sp = RST_STATE.sp;
      s_d.lim_lo = RST_STATE.lim_lo;
      s_d.lim_hi = RST_STATE.lim_hi;
      s_d.hv_fail = RST_STATE.hv_fail;
      s_d.cause = rst_ev; // RQ16
      s_d.rst_cnt = `SFM_RCNT_W'(RST_CYC);
    end
    else if (s_q.rst_cnt != '0)
      s_d.rst_cnt = s_q.rst_cnt - 1'b1;
    s_d.sec_reset = s_d.rst_cnt != '0; // RQ4
    s_d.irq = |(s_d.exc_stat & s_d.exc_en);
    s_d.active_sp = s_d.sp[mi];
  end

  // asynchronous reset to constants only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_q <= RST_STATE;
    else
      s_q <= s_d;
  end

  // ==========================================================
  // outputs, all from flops
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign dbl_read_en = s_q.ctrl[`SFM_CTRL_DBLRD]; // RQ14
  assign active_sp = s_q.active_sp;
  assign sec_reset = s_q.sec_reset;
  assign irq = s_q.irq;

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  ram_parity_rst_a: assert property (rst_ev[`SFM_CA_RAM] |=> sec_reset && s_q.cause[`SFM_CA_RAM]) // RQ2
    else $error("ram parity error did not force reset");

  scrub_parity_rst_a: assert property (sub_if.scrub_err |=> sec_reset && s_q.cause[`SFM_CA_SCRUB]) // RQ3
    else $error("scrubber parity error did not force reset");

  rom_parity_rst_a: assert property (rom_rd_valid && sfm_par4(rom_rd_data) != rom_rd_par
    |=> sec_reset && s_q.cause[`SFM_CA_ROM]) // RQ12
    else $error("rom parity error did not force reset");

  reset_pulse_len_a: assert property ($rose(sec_reset) |-> sec_reset [*8]) // RQ5
    else $error("security reset pulse too short");

  sensor_react_a: assert property (|sens_f |=> sec_reset || s_q.exc_stat[`SFM_EX_SENS]) // RQ1
    else $error("sensor alarm caused neither reset nor exception");

  sp_limit_exc_a: assert property (sp_oob && rst_ev == '0
    |=> s_q.exc_stat[`SFM_EX_SPU + $past(mi)]) // RQ9
    else $error("stack limit breach not flagged");

  hv_quiet_a: assert property (rst_ev == '0 |=> $stable(s_q.cause) && !$rose(sec_reset)) // RQ10
    else $error("reset without a reset-forcing fault");

  ecc_exc_a: assert property (sub_if.ecc_err && s_q.ctrl[`SFM_CTRL_INVECC] && rst_ev == '0
    |=> s_q.exc_stat[`SFM_EX_ECC]) // RQ13
    else $error("eeprom error not raised as exception");

  reset_wins_a: assert property (|rst_ev && |exc_ev
    |=> s_q.cause == $past(rst_ev) && s_q.exc_stat == '0) // RQ16
    else $error("exception not overruled by reset fault");

  irq_reason_a: assert property ($rose(irq) |-> (s_q.exc_stat & s_q.exc_en) != '0) // RQ6
    else $error("interrupt without a recorded reason");
endmodule : sfm_top

/* File: core/sfm_map.svh */
`ifndef SFM_MAP_SVH
`define SFM_MAP_SVH
// ==========================================================
// register offsets (byte addresses, one word each)
`define SFM_OFF_CTRL     8'h00
`define SFM_OFF_WDG_LOAD 8'h04
`define SFM_OFF_WDG_KICK 8'h08
`define SFM_OFF_EXC_STAT 8'h0C
`define SFM_OFF_EXC_CLR  8'h10
`define SFM_OFF_EXC_EN   8'h14
`define SFM_OFF_CAUSE    8'h18
`define SFM_OFF_HV_STAT  8'h1C
`define SFM_OFF_SP_BASE  8'h20
`define SFM_OFF_SP_LAST  8'h34
`define SFM_SP_STRIDE_SH 3
`define SFM_SP_HI_BIT    2
// ==========================================================
// control, exception, cause and high-voltage fields
`define SFM_CTRL_W      3
`define SFM_CTRL_DBLRD  0
`define SFM_CTRL_INVECC 1
`define SFM_CTRL_WDGEN  2
`define SFM_EXC_W       5
`define SFM_EX_SPU      0
`define SFM_EX_ECC      3
`define SFM_EX_SENS     4
`define SFM_CAUSE_W     6
`define SFM_CA_POR      0
`define SFM_CA_SENS     1
`define SFM_CA_RAM      2
`define SFM_CA_SCRUB    3
`define SFM_CA_ROM      4
`define SFM_CA_WDG      5
`define SFM_HV_FAIL     0
`define SFM_HV_BUSY     1
// ==========================================================
// timing, watchdog, scrubber and hamming constants
`define SFM_CLK_NS      4
`define SFM_RST_NS      64
`define SFM_RCNT_W      8
`define SFM_WDG_W       16
`define SFM_WDG_RST     16'hFFFF
`define SFM_SCR_MULT    16'h9E37
`define SFM_LFSR_TAPS   16'hB400
`define SFM_LFSR_SEED   16'hACE1
`define SFM_HAM_POS     32'hCBA97653
`endif

/* File: core/sfm_pkg.sv */
package sfm_pkg;
  // cpu privilege groups, one stack pointer each
  typedef enum logic [1:0] {SFM_USER, SFM_SYS, SFM_SUPER} sfm_mode_type;

  // even parity, one bit per byte
  function automatic logic [3:0] sfm_par4(input logic [31:0] d);
    logic [3:0] p;
    p = '0;
    for (int i = 0; i < 4; i++)
      p[i] = ^d[8*i +: 8];
    return p;
  endfunction : sfm_par4
endpackage : sfm_pkg

/* File: core/sfm_sub_if.sv */
`timescale 1ns/1ps
interface sfm_sub_if #(parameter int AW = 12);
  logic          ram_idle;
  logic          scrub_req;
  logic [AW-1:0] scrub_addr;
  logic          scrub_rvalid;
  logic [31:0]   scrub_rdata;
  logic [3:0]    scrub_rpar;
  logic          scrub_err;
  logic          ee_valid;
  logic [7:0]    ee_data;
  logic [3:0]    ee_chk;
  logic          corr_valid;
  logic [7:0]    corr_data;
  logic          ecc_err;
  modport scrub (input ram_idle, scrub_rvalid, scrub_rdata, scrub_rpar,
                 output scrub_req, scrub_addr, scrub_err);
  modport ecc (input ee_valid, ee_data, ee_chk,
               output corr_valid, corr_data, ecc_err);
endinterface : sfm_sub_if

/* File: core/sfm_scrub.sv */
`timescale 1ns/1ps
`include "sfm_map.svh"
module sfm_scrub #(
  parameter int AW = 12
)(
  input wire logic clk,
  input wire logic rst_n,
  sfm_sub_if.scrub bus
);
  import sfm_pkg::*;

  typedef struct packed {
    logic [15:0]   lfsr;
    logic [AW-1:0] cnt;
    logic [AW-1:0] key;
    logic [AW-1:0] addr;
    logic          req;
    logic          busy;
    logic          err;
  } sfm_scrub_state_type;

  sfm_scrub_state_type q, d;

  // odd multiply plus key is a bijection, so every word is visited per pass
  function automatic logic [AW-1:0] scram(input logic [AW-1:0] c, input logic [AW-1:0] k);
    logic [AW-1:0] m;
    m = AW'(`SFM_SCR_MULT);
    return AW'(c * m + k);
  endfunction : scram

  // ==========================================================
  // one read in flight; issue only in cycles the cpu leaves free
  always_comb
  begin
    d = q;
    d.lfsr = {q.lfsr[14:0], ^(q.lfsr & `SFM_LFSR_TAPS)};
    d.req = 1'b0;
    d.err = 1'b0;
    if (bus.scrub_rvalid && q.busy)
    begin
      d.busy = 1'b0;
      d.err = sfm_par4(bus.scrub_rdata) != bus.scrub_rpar;
      d.cnt = q.cnt + 1'b1;
      if (&q.cnt)
        d.key = q.lfsr[AW-1:0]; // new visiting order each pass
    end
    else if (!q.busy && bus.ram_idle)
    begin
      d.req = 1'b1;
      d.busy = 1'b1;
      d.addr = scram(q.cnt, q.key); // RQ3
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= '{lfsr: `SFM_LFSR_SEED, default: '0};
    else
      q <= d;
  end

  assign bus.scrub_req = q.req;
  assign bus.scrub_addr = q.addr;
  assign bus.scrub_err = q.err;
endmodule : sfm_scrub

/* File: core/sfm_ecc.sv */
`timescale 1ns/1ps
`include "sfm_map.svh"
module sfm_ecc (
  input wire logic clk,
  input wire logic rst_n,
  sfm_sub_if.ecc   bus
);
  import sfm_pkg::*;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       err;
  } sfm_ecc_state_type;

  sfm_ecc_state_type q, d;
  logic [31:0] pos;

  assign pos = `SFM_HAM_POS;

  // ==========================================================
  // hamming syndrome; a data position in it names the bit to flip
  always_comb
  begin
    logic [3:0] syn;
    syn = bus.ee_chk;
    d = q;
    d.valid = bus.ee_valid;
    d.err = 1'b0;
    if (bus.ee_valid)
    begin
      for (int i = 0; i < 8; i++)
        if (bus.ee_data[i])
          syn = syn ^ pos[4*i +: 4];
      d.data = bus.ee_data;
      for (int i = 0; i < 8; i++)
        if (syn == pos[4*i +: 4])
          d.data[i] = ~bus.ee_data[i]; // RQ11
      d.err = syn != 4'h0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= d;
  end

  assign bus.corr_valid = q.valid;
  assign bus.corr_data = q.data;
  assign bus.ecc_err = q.err;
endmodule : sfm_ecc

/* File: test/tb_top.sv */
`timescale 1ns/1ps
`include "sfm_map.svh"
module tb_top;
  import sfm_pkg::*;
  // ==========================================================
  // bench signals and counters
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, hv_ok;
  logic         ee_wr_busy, ram_rd_valid, ram_idle, scrub_req, scrub_rvalid;
  logic         rom_rd_valid, ee_rd_valid, ee_corr_valid, dbl_read_en;
  logic         sp_wr_en, sec_reset, irq;
  logic [3:0]   sens_alarm, ram_rd_par, scrub_rpar, rom_rd_par, ee_rd_chk;
  logic [7:0]   paddr, ee_rd_data, ee_corr_data;
  logic [11:0]  scrub_addr;
  logic [15:0]  sp_wr_val, active_sp;
  logic [31:0]  pwdata, prdata, ram_rd_data, scrub_rdata, rom_rd_data;
  sfm_mode_type cpu_mode;
  int           fail_count, total_checks;
  bit           seen [4096];

  sfm_top sfm_top_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sens_alarm(sens_alarm), .hv_ok(hv_ok),
    .ee_wr_busy(ee_wr_busy), .ram_rd_valid(ram_rd_valid), .ram_rd_data(ram_rd_data),
    .ram_rd_par(ram_rd_par), .ram_idle(ram_idle), .scrub_req(scrub_req),
    .scrub_addr(scrub_addr), .scrub_rvalid(scrub_rvalid), .scrub_rdata(scrub_rdata),
    .scrub_rpar(scrub_rpar), .rom_rd_valid(rom_rd_valid), .rom_rd_data(rom_rd_data),
    .rom_rd_par(rom_rd_par), .ee_rd_valid(ee_rd_valid), .ee_rd_data(ee_rd_data),
    .ee_rd_chk(ee_rd_chk), .ee_corr_valid(ee_corr_valid), .ee_corr_data(ee_corr_data),
    .dbl_read_en(dbl_read_en), .cpu_mode(cpu_mode), .sp_wr_en(sp_wr_en),
    .sp_wr_val(sp_wr_val), .active_sp(active_sp), .sec_reset(sec_reset), .irq(irq));

  // 250 MHz clock
  initial pclk = 1'b0;
  always #2 pclk = ~pclk;

  // ==========================================================
  // shared helpers
  function automatic logic [3:0] par(input logic [31:0] d);
    for (int i = 0; i < 4; i++)
      par[i] = ^d[8*i +: 8];
  endfunction : par

  // check bits sit at positions 1,2,4,8; data bits at the remaining ones
  function automatic logic [3:0] ham(input logic [7:0] d);
    int pos [8] = '{3, 5, 6, 7, 9, 10, 11, 12};
    ham = 4'h0;
    for (int i = 0; i < 8; i++)
      for (int j = 0; j < 4; j++)
        if (pos[i][j])
          ham[j] = ham[j] ^ d[i];
  endfunction : ham

  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    total_checks++;
    if (g !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask : chk

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [32:0] r);
    int n;
    n = 0;
    @(posedge pclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
    if (n >= 50)
      chk("pready", 33'h1, 33'h0);
    r = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [32:0] r;
    apb(a, 1'b1, d, r);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [32:0] e, input string nm);
    logic [32:0] r;
    apb(a, 1'b0, 32'h0, r);
    chk(nm, e, r);
  endtask : rchk

  // waits a bounded span for the forced reset, lets it run out, reads the cause
  task automatic fault(input int n, input logic [31:0] cause);
    bit hit;
    hit = 1'b0;
    for (int i = 0; i < n && !hit; i++)
    begin
      @(posedge pclk);
      hit = (sec_reset === 1'b1);
    end
    chk("sec_reset", 33'h1, {32'h0, hit});
    repeat (30) @(posedge pclk);
    rchk(`SFM_OFF_CAUSE, {1'b0, cause}, "cause");
  endtask : fault

  task automatic quiet(input int n);
    bit bad;
    bad = 1'b0;
    repeat (n)
    begin
      @(posedge pclk);
      if (sec_reset !== 1'b0 || irq !== 1'b0)
        bad = 1'b1;
    end
    chk("quiet", 33'h0, {32'h0, bad});
  endtask : quiet

  task automatic mem_rd(input bit rom, input logic [31:0] d, input logic [3:0] p);
    @(posedge pclk);
    ram_rd_valid <= !rom;
    rom_rd_valid <= rom;
    ram_rd_data <= d;
    rom_rd_data <= d;
    ram_rd_par <= p;
    rom_rd_par <= p;
    @(posedge pclk);
    ram_rd_valid <= 1'b0;
    rom_rd_valid <= 1'b0;
  endtask : mem_rd

  task automatic spw(input logic [15:0] v);
    @(posedge pclk);
    sp_wr_en <= 1'b1;
    sp_wr_val <= v;
    @(posedge pclk);
    sp_wr_en <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : spw

  // corrected byte shows one cycle after the read
  task automatic ee(input logic [7:0] d, input logic [7:0] flip);
    @(posedge pclk);
    ee_rd_valid <= 1'b1;
    ee_rd_data <= d ^ flip;
    ee_rd_chk <= ham(d);
    @(posedge pclk);
    ee_rd_valid <= 1'b0;
    @(posedge pclk);
    chk("ee_corr", {25'h1, d}, {24'h0, ee_corr_valid, ee_corr_data});
    repeat (3) @(posedge pclk);
  endtask : ee

  // ==========================================================
  // scenarios
  task automatic t_reset;
    rchk(`SFM_OFF_CAUSE, 33'h1, "cause");
    rchk(`SFM_OFF_CTRL, 33'h0, "ctrl");
    rchk(`SFM_OFF_WDG_LOAD, 33'hFFFF, "wdg_load");
    rchk(`SFM_OFF_EXC_STAT, 33'h0, "exc_stat");
    rchk(`SFM_OFF_HV_STAT, 33'h0, "hv_stat");
    rchk(8'hFC, 33'h1_0000_0000, "unmapped");
  endtask : t_reset

  task automatic t_parity;
    for (int rom = 0; rom < 2; rom++)
    begin
      wr(`SFM_OFF_CTRL, 32'h1);
      @(posedge pclk); // the control flop updates on the write edge itself
      chk("dbl_read_en", 33'h1, {32'h0, dbl_read_en});
      mem_rd(rom[0], 32'h1234_5678, par(32'h1234_5678));
      quiet(5);
      mem_rd(rom[0], 32'h1234_5678, par(32'h1234_5678) ^ 4'h4);
      fault(5, rom ? 32'h10 : 32'h04);
      chk("dbl_read_en", 33'h0, {32'h0, dbl_read_en});
    end
  endtask : t_parity

  task automatic t_stack;
    cpu_mode <= SFM_USER;
    wr(8'h20, 32'h0100);
    wr(8'h24, 32'h01FF);
    spw(16'h01FF);
    chk("active_sp", 33'h01FF, {17'h0, active_sp});
    rchk(`SFM_OFF_EXC_STAT, 33'h0, "exc_stat");
    spw(16'h0200);
    rchk(`SFM_OFF_EXC_STAT, 33'h1, "exc_stat");
    cpu_mode <= SFM_SYS;
    spw(16'h0200);
    chk("active_sp", 33'h0200, {17'h0, active_sp});
    cpu_mode <= SFM_SUPER;
    wr(`SFM_OFF_SP_LAST, 32'h00FF);
    spw(16'h0100);
    rchk(`SFM_OFF_EXC_STAT, 33'h5, "exc_stat");
    cpu_mode <= sfm_mode_type'(2'h3);
    repeat (2) @(posedge pclk);
    chk("active_sp", 33'h0100, {17'h0, active_sp});
    wr(`SFM_OFF_EXC_EN, 32'h7);
    repeat (3) @(posedge pclk);
    chk("irq", 33'h1, {32'h0, irq});
    wr(`SFM_OFF_EXC_CLR, 32'h7);
    repeat (3) @(posedge pclk);
    chk("irq", 33'h0, {32'h0, irq});
    // parity fault and stack fault land on the same edge
    @(posedge pclk);
    ram_rd_valid <= 1'b1;
    ram_rd_par <= par(ram_rd_data) ^ 4'h1;
    sp_wr_en <= 1'b1;
    sp_wr_val <= 16'h0300;
    @(posedge pclk);
    ram_rd_valid <= 1'b0;
    sp_wr_en <= 1'b0;
    fault(5, 32'h04);
    rchk(`SFM_OFF_EXC_STAT, 33'h0, "exc_stat");
  endtask : t_stack

  task automatic t_ecc;
    for (int b = 0; b < 8; b++)
      ee(8'h3C + 8'(b), 8'h1 << b);
    wr(`SFM_OFF_CTRL, 32'h2);
    wr(`SFM_OFF_EXC_EN, 32'h8);
    ee(8'hA5, 8'h10);
    rchk(`SFM_OFF_EXC_STAT, 33'h8, "exc_stat");
    chk("irq", 33'h1, {32'h0, irq});
    wr(`SFM_OFF_CTRL, 32'h0);
    wr(`SFM_OFF_EXC_CLR, 32'h8);
    ee(8'h5A, 8'h02);
    rchk(`SFM_OFF_EXC_STAT, 33'h0, "exc_stat");
  endtask : t_ecc

  // software clears the control and exception-enable registers first; alarms must still force a reset
  task automatic t_sens;
    for (int s = 0; s < 4; s++)
    begin
      wr(`SFM_OFF_CTRL, 32'h0);
      wr(`SFM_OFF_EXC_EN, 32'h0);
      sens_alarm <= 4'h1 << s;
      repeat (8) @(posedge pclk);
      sens_alarm <= 4'h0;
      fault(10, 32'h02);
    end
  endtask : t_sens

  task automatic t_hv;
    wr(`SFM_OFF_EXC_EN, 32'h1F);
    ee_wr_busy <= 1'b1;
    hv_ok <= 1'b0;
    quiet(8);
    rchk(`SFM_OFF_HV_STAT, 33'h3, "hv_stat");
    ee_wr_busy <= 1'b0;
    hv_ok <= 1'b1;
    quiet(8);
    rchk(`SFM_OFF_HV_STAT, 33'h1, "hv_stat");
    ee_wr_busy <= 1'b1;
    quiet(8);
    rchk(`SFM_OFF_HV_STAT, 33'h2, "hv_stat");
    ee_wr_busy <= 1'b0;
  endtask : t_hv

  task automatic t_wdg;
    wr(`SFM_OFF_WDG_LOAD, 32'd20);
    wr(`SFM_OFF_WDG_KICK, 32'h0);
    wr(`SFM_OFF_CTRL, 32'h4);
    quiet(12);
    fault(20, 32'h20);
  endtask : t_wdg

  // answer a full pass of scrub requests, then a bad word
  task automatic t_scrub;
    int n;
    int hits;
    hits = 0;
    ram_idle <= 1'b1;
    for (int k = 0; k < 4097; k++)
    begin
      n = 0;
      do @(posedge pclk); while (scrub_req !== 1'b1 && ++n < 20);
      if (n >= 20)
        chk("scrub_req", 33'h1, 33'h0);
      if (k < 4096)
        seen[scrub_addr] = 1'b1;
      scrub_rvalid <= 1'b1;
      scrub_rdata <= 32'(k);
      scrub_rpar <= par(32'(k)) ^ ((k == 4096) ? 4'h2 : 4'h0);
      @(posedge pclk);
      scrub_rvalid <= 1'b0;
    end
    foreach (seen[i])
      hits += seen[i];
    chk("scrub_cover", 33'd4096, 33'(hits));
    fault(10, 32'h08);
    ram_idle <= 1'b0;
  endtask : t_scrub

  // ==========================================================
  // run control
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude

  initial
  begin
    {presetn, psel, penable, pwrite, ee_wr_busy, ram_rd_valid, ram_idle} = '0;
    {scrub_rvalid, rom_rd_valid, ee_rd_valid, sp_wr_en, paddr, pwdata} = '0;
    {sens_alarm, ram_rd_par, scrub_rpar, rom_rd_par, ee_rd_chk, ee_rd_data} = '0;
    {ram_rd_data, scrub_rdata, rom_rd_data, sp_wr_val} = '0;
    hv_ok = 1'b1;
    cpu_mode = SFM_USER;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_parity();
    t_stack();
    t_ecc();
    t_sens();
    t_hv();
    t_wdg();
    t_scrub();
    conclude();
  end

  // hang guard, about twice the expected run; the scrub pass dominates
  initial
  begin
    #120000;
    $display("MISMATCH run_time expected finish seen hang");
    fail_count++;
    conclude();
  end
endmodule : tb_top
